// File: hw/timekeeping_nv_ram_port.sv
// Byte-wide port onto a nonvolatile RAM with clock, alarm, watchdog and reset control
`timescale 1ns/100ps
`include "rtc_map.svh"
// Operation
// RULE1: 128k bytes, clock in top sixteen locations
// RULE2: BCD time and calendar, 24-hour hours
// RULE3: Month length and leap years corrected automatically
// RULE4: Century register keeps the four-digit year
// RULE5: Internal copy counts; host sees external copy
// RULE6: Host can freeze and resume external updates
// RULE7: After write freeze, load internal from external
// RULE8: Alarm match drives the interrupt output
// RULE9: Battery-mode alarm only when enabled
// RULE10: Watchdog timeout drives interrupt or reset
// RULE11: Power fail holds reset output active
// RULE12: Out of tolerance: strobes ignored, lines released
// RULE13: Interrupt and reset outputs are open-drain
// RULE14: Select low, write high means read
// RULE15: Read data follows the address
// RULE16: Drive lines only when selected and enabled
// RULE17: Flag reports backup battery level
// RULE18: Write while select and write strobe low
// RULE19: Reset held 40 to 200 ms after recovery
// RULE20: Battery flag bit 4 of flags, read-only
module timekeeping_nv_ram_port #(
  parameter int AW = 17,
  parameter int DW = 8,
  parameter int TICK_CYCLES = `TICK_CYCLES,
  parameter int POR_CYCLES = `POR_CYCLES,
  parameter int WD_UNIT_CYCLES = `WD_UNIT_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Host memory port
  input wire logic [AW-1:0] location_lines,
  input wire logic chip_sel_n,
  input wire logic out_en_n,
  input wire logic write_en_n,
  input wire logic [DW-1:0] byte_lines_in,
  output logic [DW-1:0] byte_lines_out,
  output logic byte_lines_oe_n,
  // Open-drain interrupt and reset pins
  input wire logic alarm_or_test_in,
  output logic alarm_or_test_out_n,
  output logic alarm_or_test_oe_n,
  input wire logic reset_line_in,
  output logic reset_line_out_n,
  output logic reset_line_oe_n,
  // Supply monitor
  input wire logic power_fail,
  input wire logic battery_mode,
  input wire logic battery_low
);
  import rtc_pkg::*;

  port_state_t port_state;
  port_state_t next_port_state;
  logic [7:0] regs [16];
  logic [AW-1:0] wr_addr;
  logic [DW-1:0] wr_data;
  logic [DW-1:0] mem_rd;
  logic [7:0] reg_rd;
  logic read_cond, write_cond, drive_cond;
  logic wr_commit, wr_region, clk_write, mem_write;
  logic in_region, in_region_q;
  logic rd_flags, rd_flags_q, flags_clr;
  logic halted, w_prev, load_int;
  logic [31:0] tick_cnt;
  logic tick, tick_q;
  logic [7:0] int_sec, int_min, int_hour, int_day, int_date, int_month, int_year, int_cent;
  logic alarm_hit, irq_req, next_wf, next_af;
  logic [39:0] wd_cnt, wd_limit;
  logic [4:0] wd_mult;
  logic wd_kick, wd_kick_q, wd_expire;
  logic [31:0] por_cnt;

  // Strobe decode; a failing supply blocks every access
  assign read_cond = !chip_sel_n && write_en_n && !power_fail; // RULE14
  assign write_cond = !chip_sel_n && !write_en_n && !power_fail; // RULE18
  assign drive_cond = read_cond && !out_en_n; // RULE16
  assign in_region = (location_lines[AW-1:4] == (AW-4)'(`CLK_REGION)); // RULE1
  assign wr_region = (wr_addr[AW-1:4] == (AW-4)'(`CLK_REGION));

  always_comb begin
    if (power_fail) begin
      next_port_state = PORT_BLOCKED; // RULE12
    end else if (write_cond) begin
      next_port_state = PORT_WRITE;
    end else if (read_cond) begin
      next_port_state = PORT_READ;
    end else begin
      next_port_state = PORT_IDLE;
    end
  end

  // Commit at the end of the write; a write cut short by a power fail is dropped
  always_comb begin
    case (port_state)
      PORT_WRITE: wr_commit = (next_port_state == PORT_READ) || (next_port_state == PORT_IDLE);
      default: wr_commit = 1'b0;
    endcase
  end

  assign clk_write = wr_commit && wr_region; // RULE1
  assign mem_write = wr_commit && !wr_region;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      port_state <= PORT_IDLE;
    end else begin
      port_state <= next_port_state;
    end
  end

  // Last sampled data before the strobes rise is what gets written
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_addr <= '0;
      wr_data <= '0;
    end else if (write_cond) begin // RULE18
      wr_addr <= location_lines;
      wr_data <= byte_lines_in;
    end
  end

  nv_store #(
    .AW(AW),
    .DW(DW)
  ) u_store (
    .clk(clk),
    .wr_en(mem_write),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .rd_addr(location_lines),
    .rd_data(mem_rd)
  );

  // Second tick from the core clock; stopping the oscillator holds it
  assign tick = (tick_cnt == 32'(TICK_CYCLES - 1));

  always_ff @(posedge clk) begin
    if (!rst_n || regs[`IDX_SEC][`BIT_OSC] || tick) begin
      tick_cnt <= '0;
    end else begin
      tick_cnt <= tick_cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tick_q <= 1'b0;
    end else begin
      tick_q <= tick;
    end
  end

  // Freeze and resume of the external copy
  assign halted = regs[`IDX_CTRL][`BIT_CW] || regs[`IDX_CTRL][`BIT_CR]; // RULE6
  assign load_int = w_prev && !regs[`IDX_CTRL][`BIT_CW]; // RULE7

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      w_prev <= 1'b0;
    end else begin
      w_prev <= regs[`IDX_CTRL][`BIT_CW];
    end
  end

  calendar_counter u_calendar (
    .clk(clk),
    .rst_n(rst_n),
    .tick(tick),
    .run(!regs[`IDX_SEC][`BIT_OSC]),
    .load(load_int),
    .ld_sec({1'b0, regs[`IDX_SEC][6:0]}),
    .ld_min(regs[`IDX_MIN]),
    .ld_hour(regs[`IDX_HOUR]),
    .ld_day({5'h00, regs[`IDX_DAY][2:0]}),
    .ld_date(regs[`IDX_DATE]),
    .ld_month(regs[`IDX_MONTH]),
    .ld_year(regs[`IDX_YEAR]),
    .ld_cent({2'h0, regs[`IDX_CTRL][5:0]}),
    .sec(int_sec),
    .min(int_min),
    .hour(int_hour),
    .day(int_day),
    .date(int_date),
    .month(int_month),
    .year(int_year),
    .cent(int_cent)
  );

  // Alarm compares once per second, right after the internal set has moved
  assign alarm_hit = tick_q && // RULE8
    (regs[`IDX_ALM_SEC][`BIT_AMASK] || (regs[`IDX_ALM_SEC][6:0] == int_sec[6:0])) &&
    (regs[`IDX_ALM_MIN][`BIT_AMASK] || (regs[`IDX_ALM_MIN][6:0] == int_min[6:0])) &&
    (regs[`IDX_ALM_HOUR][`BIT_AMASK] || (regs[`IDX_ALM_HOUR][5:0] == int_hour[5:0])) &&
    (regs[`IDX_ALM_DATE][`BIT_AMASK] || (regs[`IDX_ALM_DATE][5:0] == int_date[5:0]));

  // Flags clear on the first cycle of a read of the flags location
  assign rd_flags = read_cond && in_region && (location_lines[3:0] == `IDX_FLAGS);
  assign flags_clr = rd_flags && !rd_flags_q;
  assign next_wf = (wd_expire && !regs[`IDX_WDOG][`BIT_WDS]) || // RULE10
    (regs[`IDX_FLAGS][`BIT_WF] && !flags_clr);
  assign next_af = alarm_hit || (regs[`IDX_FLAGS][`BIT_AF] && !flags_clr); // RULE8

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_flags_q <= 1'b0;
    end else begin
      rd_flags_q <= rd_flags;
    end
  end

  // Register file: refresh from the internal set, then host writes, then flags
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < 16; i++) begin
        regs[i] <= `REG_RST;
      end
    end else begin
      if (!halted) begin // RULE5
        regs[`IDX_SEC] <= {regs[`IDX_SEC][`BIT_OSC], int_sec[6:0]};
        regs[`IDX_MIN] <= int_min;
        regs[`IDX_HOUR] <= int_hour; // RULE2
        regs[`IDX_DAY] <= {regs[`IDX_DAY][7:3], int_day[2:0]};
        regs[`IDX_DATE] <= int_date;
        regs[`IDX_MONTH] <= int_month;
        regs[`IDX_YEAR] <= int_year;
        regs[`IDX_CTRL] <= {regs[`IDX_CTRL][7:6], int_cent[5:0]}; // RULE4
      end
      if (clk_write) begin
        regs[wr_addr[3:0]] <= wr_data;
      end
      // Flags are hardware-owned, so any host write there is overridden
      regs[`IDX_FLAGS] <= {next_wf, next_af, 1'b0, battery_low, 4'h0}; // RULE20
    end
  end

  // Watchdog: any write to its register with a nonzero multiplier restarts the count; a zero multiplier stops it
  assign wd_mult = regs[`IDX_WDOG][6:2];
  assign wd_limit = 40'(wd_mult) * (40'(WD_UNIT_CYCLES) << {regs[`IDX_WDOG][1:0], 1'b0});
  assign wd_kick = clk_write && (wr_addr[3:0] == `IDX_WDOG);
  assign wd_expire = (wd_mult != 5'h00) && (wd_cnt == 40'h00_0000_0001); // RULE10

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wd_kick_q <= 1'b0;
    end else begin
      wd_kick_q <= wd_kick;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || (wd_mult == 5'h00)) begin
      wd_cnt <= '0;
    end else if (wd_kick_q || wd_expire) begin
      wd_cnt <= wd_limit;
    end else if (wd_cnt != '0) begin
      wd_cnt <= wd_cnt - 40'h00_0000_0001;
    end
  end

  // Reset hold runs from the core clock, not the oscillator
  always_ff @(posedge clk) begin
    if (!rst_n || power_fail) begin
      por_cnt <= 32'(POR_CYCLES); // RULE11
    end else if (wd_expire && regs[`IDX_WDOG][`BIT_WDS]) begin
      por_cnt <= 32'(POR_CYCLES); // RULE10
    end else if (por_cnt != '0) begin
      por_cnt <= por_cnt - 32'h0000_0001; // RULE19
    end
  end

  assign irq_req = (regs[`IDX_FLAGS][`BIT_AF] && regs[`IDX_INTR][`BIT_AE] &&
    (!battery_mode || regs[`IDX_INTR][`BIT_ABE])) || // RULE9
    (regs[`IDX_FLAGS][`BIT_WF] && !regs[`IDX_WDOG][`BIT_WDS]);

  // Open-drain pins: value is always low, only the enable moves
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      alarm_or_test_out_n <= 1'b0;
      reset_line_out_n <= 1'b0;
      alarm_or_test_oe_n <= 1'b1;
      reset_line_oe_n <= 1'b0;
    end else begin
      alarm_or_test_out_n <= 1'b0; // RULE13
      reset_line_out_n <= 1'b0;
      alarm_or_test_oe_n <= !irq_req; // RULE8
      reset_line_oe_n <= !(power_fail || (por_cnt != '0)); // RULE11
    end
  end

  // Read path: two flops behind the address so pins come from registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reg_rd <= '0;
      in_region_q <= 1'b0;
      byte_lines_out <= '0;
      byte_lines_oe_n <= 1'b1;
    end else begin
      reg_rd <= regs[location_lines[3:0]]; // RULE15
      in_region_q <= in_region;
      byte_lines_out <= in_region_q ? reg_rd : mem_rd; // RULE1
      byte_lines_oe_n <= !drive_cond; // RULE16
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_blocked_no_drive: assert property (power_fail |=> byte_lines_oe_n) // RULE12
    else $error("data lines driven during power fail");
  chk_drive_needs_select: assert property (!byte_lines_oe_n |-> // RULE16
    $past(!chip_sel_n && !out_en_n && write_en_n)) else $error("data lines driven unselected");
  chk_read_mode: assert property ((!chip_sel_n && write_en_n && !power_fail) |=> // RULE14
    (port_state == PORT_READ)) else $error("read cycle not recognised");
  chk_reset_on_fail: assert property (power_fail |=> !reset_line_oe_n) // RULE11
    else $error("reset not driven on power fail");
  chk_por_hold: assert property ($fell(power_fail) |=> !reset_line_oe_n [*8]) // RULE19
    else $error("reset released too early");
  chk_alarm_irq: assert property ($past(alarm_hit) && !battery_mode && // RULE8
    regs[`IDX_INTR][`BIT_AE] |=> !alarm_or_test_oe_n) else $error("alarm did not interrupt");
  chk_battery_gate: assert property ((battery_mode && !regs[`IDX_INTR][`BIT_ABE] && // RULE9
    !regs[`IDX_FLAGS][`BIT_WF]) |=> alarm_or_test_oe_n) else $error("battery alarm not gated");
  chk_wdog_steer: assert property ((wd_expire && regs[`IDX_WDOG][`BIT_WDS]) |=> // RULE10
    ##1 !reset_line_oe_n) else $error("watchdog reset missing");
  chk_batt_flag: assert property (battery_low |=> regs[`IDX_FLAGS][`BIT_BLF]) // RULE17
    else $error("battery flag does not follow monitor");
  chk_freeze_holds: assert property ((halted && $past(halted) && !$past(clk_write)) |-> // RULE6
    $stable(regs[`IDX_SEC])) else $error("frozen seconds changed");
  chk_write_loads: assert property (load_int |=> (int_min == $past(regs[`IDX_MIN]))) // RULE7
    else $error("internal set not loaded");

  cov_read_drive: cover property (drive_cond ##2 !byte_lines_oe_n);
  cov_clock_write: cover property (clk_write);
  cov_alarm_fire: cover property (alarm_hit);
  cov_wdog_reset: cover property (wd_expire && regs[`IDX_WDOG][`BIT_WDS]);
endmodule

// File: hw/rtc_map.svh
// Offsets, field positions, reset values and timing counts of the timekeeping RAM port
`ifndef RTC_MAP_SVH
`define RTC_MAP_SVH

// Clock registers occupy the top 16 locations
`define CLK_REGION 13'h1FFF
`define IDX_FLAGS 4'h0
`define IDX_UNUSED 4'h1
`define IDX_ALM_SEC 4'h2
`define IDX_ALM_MIN 4'h3
`define IDX_ALM_HOUR 4'h4
`define IDX_ALM_DATE 4'h5
`define IDX_INTR 4'h6
`define IDX_WDOG 4'h7
`define IDX_CTRL 4'h8
`define IDX_SEC 4'h9
`define IDX_MIN 4'hA
`define IDX_HOUR 4'hB
`define IDX_DAY 4'hC
`define IDX_DATE 4'hD
`define IDX_MONTH 4'hE
`define IDX_YEAR 4'hF

// Field positions
`define BIT_WF 7
`define BIT_AF 6
`define BIT_BLF 4
`define BIT_CW 7
`define BIT_CR 6
`define BIT_OSC 7
`define BIT_AE 7
`define BIT_ABE 5
`define BIT_WDS 7
`define BIT_AMASK 7

// Reset values
`define REG_RST 8'h00
`define SEC_RST 8'h00
`define DAY_RST 8'h01
`define DATE_RST 8'h01
`define MONTH_RST 8'h01
`define YEAR_RST 8'h00
`define CENT_RST 8'h20
`define CENT_MAX 8'h39

// Timing
`define CLK_HZ 40000000
`define TICK_CYCLES (`CLK_HZ)
`define POR_MIN_MS 40
`define POR_MAX_MS 200
`define POR_CYCLES (`POR_MIN_MS * (`CLK_HZ / 1000))
`define WD_UNIT_MS 10
`define WD_UNIT_CYCLES (`WD_UNIT_MS * (`CLK_HZ / 1000))

`endif

// File: hw/rtc_pkg.sv
// Types shared by the timekeeping RAM port
package rtc_pkg;
  typedef enum logic [1:0] {
    PORT_IDLE,
    PORT_READ,
    PORT_WRITE,
    PORT_BLOCKED
  } port_state_t;
endpackage

// File: hw/nv_store.sv
// Byte-wide storage array with registered read data
`timescale 1ns/100ps
module nv_store #(
  parameter int AW = 17,
  parameter int DW = 8
) (
  // Clock
  input wire logic clk,
  // Write side
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [DW-1:0] wr_data,
  // Read side
  input wire logic [AW-1:0] rd_addr,
  output logic [DW-1:0] rd_data
);
  logic [DW-1:0] cells [2**AW];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      cells[wr_addr] <= wr_data;
    end
  end

  // A read in the cycle of a write to the same cell returns the old byte
  always_ff @(posedge clk) begin
    rd_data <= cells[rd_addr];
  end
endmodule

// File: hw/calendar_counter.sv
// Internal BCD clock and calendar set that counts on each second tick
`timescale 1ns/100ps
`include "rtc_map.svh"
module calendar_counter (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic tick,
  input wire logic run,
  input wire logic load,
  // Load values
  input wire logic [7:0] ld_sec,
  input wire logic [7:0] ld_min,
  input wire logic [7:0] ld_hour,
  input wire logic [7:0] ld_day,
  input wire logic [7:0] ld_date,
  input wire logic [7:0] ld_month,
  input wire logic [7:0] ld_year,
  input wire logic [7:0] ld_cent,
  // Current time
  output logic [7:0] sec,
  output logic [7:0] min,
  output logic [7:0] hour,
  output logic [7:0] day,
  output logic [7:0] date,
  output logic [7:0] month,
  output logic [7:0] year,
  output logic [7:0] cent
);
  logic c_sec, c_min, c_hour, c_date, c_month, c_year;

  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    return (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
  endfunction

  // Year taken as leap when divisible by four; holds through 2099
  function automatic logic [7:0] last_date(input logic [7:0] m, input logic [7:0] y);
    logic leap;
    leap = (({y[4], 1'b0} + y[1:0]) == 2'b00);
    case (m)
      8'h02: last_date = leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: last_date = 8'h30;
      default: last_date = 8'h31;
    endcase
  endfunction

  assign c_sec = (sec == 8'h59);
  assign c_min = c_sec && (min == 8'h59);
  assign c_hour = c_min && (hour == 8'h23); // RULE2
  assign c_date = c_hour && (date == last_date(month, year)); // RULE3
  assign c_month = c_date && (month == 8'h12);
  assign c_year = c_month && (year == 8'h99);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sec <= `SEC_RST;
      min <= `SEC_RST;
      hour <= `SEC_RST;
      day <= `DAY_RST;
      date <= `DATE_RST;
      month <= `MONTH_RST;
      year <= `YEAR_RST;
      cent <= `CENT_RST;
    end else if (load) begin
      sec <= ld_sec;
      min <= ld_min;
      hour <= ld_hour;
      day <= ld_day;
      date <= ld_date;
      month <= ld_month;
      year <= ld_year;
      cent <= ld_cent;
    end else if (tick && run) begin // RULE5
      sec <= c_sec ? 8'h00 : bcd_inc(sec);
      if (c_sec) begin
        min <= c_min ? 8'h00 : bcd_inc(min);
      end
      if (c_min) begin
        hour <= c_hour ? 8'h00 : bcd_inc(hour); // RULE2
      end
      if (c_hour) begin
        day <= (day == 8'h07) ? 8'h01 : bcd_inc(day);
        date <= c_date ? 8'h01 : bcd_inc(date); // RULE3
      end
      if (c_date) begin
        month <= c_month ? 8'h01 : bcd_inc(month);
      end
      if (c_month) begin
        year <= c_year ? 8'h00 : bcd_inc(year);
      end
      if (c_year) begin
        cent <= (cent == `CENT_MAX) ? 8'h00 : bcd_inc(cent); // RULE4
      end
    end
  end
endmodule

// File: testbench/host_model.sv
// Host processor model that drives the byte-wide memory strobes
`timescale 1ns/100ps
module host_model (
  // Clock
  input wire logic clk,
  // Address and strobes
  output logic [16:0] location_lines,
  output logic chip_sel_n,
  output logic out_en_n,
  output logic write_en_n,
  // Data lines
  output logic [7:0] host_data,
  output logic host_drive,
  input wire logic [7:0] bus_data,
  input wire logic bus_oe_n
);
  initial begin
    location_lines = 17'h0_0000;
    chip_sel_n = 1'b1;
    out_en_n = 1'b1;
    write_en_n = 1'b1;
    host_data = 8'h00;
    host_drive = 1'b0;
  end

  // Address and data stay put through the edge that sees the strobes rise
  task automatic wr(input logic [16:0] a, input logic [7:0] d, input int hold);
    @(posedge clk);
    location_lines <= a;
    host_data <= d;
    host_drive <= 1'b1;
    out_en_n <= 1'b1;
    chip_sel_n <= 1'b0;
    write_en_n <= 1'b0;
    repeat (hold) @(posedge clk);
    chip_sel_n <= 1'b1;
    write_en_n <= 1'b1;
    @(posedge clk);
    host_drive <= 1'b0;
    // Gap before the next access, long enough for read-after-write
    repeat (3) @(posedge clk);
  endtask

  // Leaves the part selected, so a following call changes only the address
  task automatic rd(input logic [16:0] a, input logic oe_n, output logic [7:0] d,
                    output logic seen_oe_n);
    @(posedge clk);
    location_lines <= a;
    chip_sel_n <= 1'b0;
    out_en_n <= oe_n;
    repeat (4) @(posedge clk);
    #1;
    d = bus_data;
    seen_oe_n = bus_oe_n;
  endtask

  task automatic idle();
    @(posedge clk);
    chip_sel_n <= 1'b1;
    out_en_n <= 1'b1;
  endtask
endmodule

// File: testbench/tb.sv
// Self-checking bench for the timekeeping RAM port
`timescale 1ns/100ps
`include "rtc_map.svh"
module tb;
  localparam int TICK = 20;
  localparam int POR = 20;
  localparam logic [16:0] TOP = 17'h1_FFF0;
  logic clk, rst_n, power_fail, battery_mode, battery_low;
  logic [16:0] location_lines;
  logic chip_sel_n, out_en_n, write_en_n, host_drive;
  logic [7:0] byte_lines_in, byte_lines_out, host_data, bus_data;
  logic byte_lines_oe_n, alarm_or_test_out_n, alarm_or_test_oe_n;
  logic reset_line_out_n, reset_line_oe_n, alarm_pin, reset_pin;
  int n_errors = 0;
  int tests_run = 0;
  integer seed = 32'h0000_3d7b;
  logic [7:0] mem [int];
  logic [16:0] addrs [$];
  // {month, date, year, century} before and after one rollover at 23:59:59
  logic [31:0] start_v [4] = '{32'h0228_2320, 32'h0228_2420, 32'h0430_2420, 32'h1231_9920};
  logic [31:0] exp_v [4] = '{32'h0301_2320, 32'h0229_2420, 32'h0501_2420, 32'h0101_0021};

  // Released lines show the inverse of the last value; open-drain pins pull up
  assign byte_lines_in = host_drive ? host_data : ~host_data;
  assign bus_data = !byte_lines_oe_n ? byte_lines_out : ~host_data;
  assign alarm_pin = alarm_or_test_oe_n ? 1'b1 : alarm_or_test_out_n;
  assign reset_pin = reset_line_oe_n ? 1'b1 : reset_line_out_n;

  timekeeping_nv_ram_port #(.TICK_CYCLES(TICK), .POR_CYCLES(POR), .WD_UNIT_CYCLES(4)) dut (
    .clk(clk), .rst_n(rst_n), .location_lines(location_lines), .chip_sel_n(chip_sel_n),
    .out_en_n(out_en_n), .write_en_n(write_en_n), .byte_lines_in(byte_lines_in),
    .byte_lines_out(byte_lines_out), .byte_lines_oe_n(byte_lines_oe_n),
    .alarm_or_test_in(alarm_pin), .alarm_or_test_out_n(alarm_or_test_out_n),
    .alarm_or_test_oe_n(alarm_or_test_oe_n), .reset_line_in(reset_pin),
    .reset_line_out_n(reset_line_out_n), .reset_line_oe_n(reset_line_oe_n),
    .power_fail(power_fail), .battery_mode(battery_mode), .battery_low(battery_low));

  host_model host (
    .clk(clk), .location_lines(location_lines), .chip_sel_n(chip_sel_n),
    .out_en_n(out_en_n), .write_en_n(write_en_n), .host_data(host_data),
    .host_drive(host_drive), .bus_data(bus_data), .bus_oe_n(byte_lines_oe_n));

  function automatic logic [16:0] ra(input logic [3:0] i);
    return {`CLK_REGION, i};
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic rdc(input logic [16:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic o;
    host.rd(a, 1'b0, d, o);
    check(d, exp);
    host.idle();
  endtask

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // The whole sequence needs under 4000 cycles
  initial begin
    #(25 * 20000);
    n_errors++;
    results();
  end

  initial begin
    logic [7:0] d;
    logic o;
    logic [16:0] a;
    rst_n = 1'b0;
    power_fail = 1'b0;
    battery_mode = 1'b0;
    battery_low = 1'b0;
    cyc(1);
    check(reset_pin, 1'b0);
    check(byte_lines_oe_n, 1'b1);
    check(alarm_pin, 1'b1);
    @(posedge clk) rst_n <= 1'b1;
    cyc(POR - 2);
    check(reset_pin, 1'b0);
    cyc(6);
    check(reset_pin, 1'b1);
    // Plain memory, both ends of the array and random places below the clock
    for (int i = 0; i < 12; i++) begin
      a = (i == 0) ? 17'h0_0000 : (i == 1) ? 17'h1_FFEF : 17'($random(seed));
      if (a[16:4] == `CLK_REGION) a[4] = 1'b0;
      d = 8'($random(seed));
      mem[int'(a)] = d;
      addrs.push_back(a);
      host.wr(a, d, i % 3 + 1);
    end
    // Address changes while selected: no deselect between reads
    foreach (addrs[i]) begin
      host.rd(addrs[i], 1'b0, d, o);
      check(d, mem[int'(addrs[i])]);
    end
    host.idle();
    host.rd(addrs[0], 1'b1, d, o);
    check(o, 1'b1);
    host.idle();
    host.wr(TOP, 8'hFF, 1);
    rdc(TOP, 8'h00);
    @(posedge clk) battery_low <= 1'b1;
    rdc(TOP, 8'h10);
    @(posedge clk) battery_low <= 1'b0;
    // Calendar rollovers: month end, leap day, century
    for (int k = 0; k < 4; k++) begin
      host.wr(ra(`IDX_CTRL), 8'h80 | start_v[k][7:0], 1);
      host.wr(ra(`IDX_SEC), 8'h59, 1);
      host.wr(ra(`IDX_MIN), 8'h59, 1);
      host.wr(ra(`IDX_HOUR), 8'h23, 1);
      host.wr(ra(`IDX_DATE), start_v[k][23:16], 1);
      host.wr(ra(`IDX_MONTH), start_v[k][31:24], 1);
      host.wr(ra(`IDX_YEAR), start_v[k][15:8], 1);
      cyc(3 * TICK);
      rdc(ra(`IDX_HOUR), 8'h23);
      host.wr(ra(`IDX_CTRL), start_v[k][7:0], 1);
      cyc(TICK + 5);
      rdc(ra(`IDX_HOUR), 8'h00);
      rdc(ra(`IDX_DATE), exp_v[k][23:16]);
      rdc(ra(`IDX_MONTH), exp_v[k][31:24]);
      rdc(ra(`IDX_YEAR), exp_v[k][15:8]);
      rdc(ra(`IDX_CTRL), exp_v[k][7:0]);
    end
    host.wr(ra(`IDX_CTRL), 8'h61, 1);
    host.wr(ra(`IDX_SEC), 8'h45, 1);
    cyc(3 * TICK);
    rdc(ra(`IDX_SEC), 8'h45);
    host.wr(ra(`IDX_CTRL), 8'h21, 1);
    // Every alarm field masked: a match on each second
    for (int i = 2; i < 6; i++) host.wr(ra(4'(i)), 8'h80, 1);
    host.wr(ra(`IDX_INTR), 8'h80, 1);
    cyc(3 * TICK);
    check(alarm_pin, 1'b0);
    @(posedge clk) battery_mode <= 1'b1;
    cyc(3);
    check(alarm_pin, 1'b1);
    host.wr(ra(`IDX_INTR), 8'hA0, 1);
    cyc(3 * TICK);
    check(alarm_pin, 1'b0);
    @(posedge clk) battery_mode <= 1'b0;
    host.wr(ra(`IDX_INTR), 8'h00, 1);
    for (int i = 2; i < 6; i++) host.wr(ra(4'(i)), 8'h00, 1);
    host.rd(TOP, 1'b0, d, o);
    host.idle();
    cyc(3);
    check(alarm_pin, 1'b1);
    // Watchdog of 31 units steered to the interrupt, kicked once
    host.wr(ra(`IDX_WDOG), 8'h7C, 1);
    cyc(100);
    check(alarm_pin, 1'b1);
    host.wr(ra(`IDX_WDOG), 8'h7C, 1);
    cyc(100);
    check(alarm_pin, 1'b1);
    cyc(40);
    check(alarm_pin, 1'b0);
    host.wr(ra(`IDX_WDOG), 8'hFC, 1);
    cyc(130);
    check(reset_pin, 1'b0);
    host.wr(ra(`IDX_WDOG), 8'h00, 1);
    host.rd(TOP, 1'b0, d, o);
    host.idle();
    cyc(POR + 5);
    check(alarm_pin, 1'b1);
    // Second range: one unit scaled once, steered to the interrupt
    host.wr(ra(`IDX_WDOG), 8'h05, 1);
    cyc(10);
    check(alarm_pin, 1'b1);
    cyc(8);
    check(alarm_pin, 1'b0);
    host.wr(ra(`IDX_WDOG), 8'h00, 1);
    host.rd(TOP, 1'b0, d, o);
    host.idle();
    // Stopped oscillator: seconds must not move
    host.wr(ra(`IDX_SEC), 8'h80, 1);
    host.rd(ra(`IDX_SEC), 1'b0, d, o);
    host.idle();
    cyc(3 * TICK);
    rdc(ra(`IDX_SEC), d);
    host.wr(ra(`IDX_SEC), 8'h00, 1);
    // Supply fails in mid-write: the write is lost and the port goes dead
    a = addrs[2];
    fork
      host.wr(a, ~mem[int'(a)], 2);
      begin
        @(posedge clk);
        @(posedge clk) power_fail <= 1'b1;
      end
    join
    host.rd(a, 1'b0, d, o);
    check(o, 1'b1);
    host.idle();
    check(reset_pin, 1'b0);
    @(posedge clk) power_fail <= 1'b0;
    cyc(POR - 2);
    check(reset_pin, 1'b0);
    cyc(6);
    check(reset_pin, 1'b1);
    rdc(a, mem[int'(a)]);
    results();
  end
endmodule
